// ===== adc_front_model.sv
`timescale 1ns/1ns
module adc_front_model (
	input  wire logic        clk_in,
	input  wire logic        req_in,
	input  wire logic        sel_in,
	input  wire logic [15:0] shunt_in,
	input  wire logic [15:0] bus_in,
	input  wire logic [10:0] count_in,
	input  wire logic [1:0]  gap_in,
	output logic [15:0]      data_out,
	output logic             valid_out
);
	logic [10:0] cnt_ff;
	logic [1:0]  wait_ff;
	logic        sel_ff;
	initial begin
		data_out = 16'h0000;
		valid_out = 1'b0;
		cnt_ff = 11'h000;
		wait_ff = 2'h0;
		sel_ff = 1'b0;
	end
	// falling edge keeps updates clear of the sampling edge
	always @(negedge clk_in) begin
		if (!req_in || sel_in != sel_ff) begin
			cnt_ff = 11'h000;
			wait_ff = gap_in;
		end
		sel_ff = sel_in;
		// free-running while requested; offsets wrap so any run of count_in samples averages exactly
		if (req_in && wait_ff == 2'h0) begin
			valid_out <= 1'b1;
			data_out <= (sel_in ? bus_in : shunt_in) + {5'h00, cnt_ff};
			cnt_ff = (cnt_ff + 11'h001 >= count_in) ? 11'h000 : cnt_ff + 11'h001;
			wait_ff = gap_in;
		end else begin
			valid_out <= 1'b0;
			// idle word: inverse of last, never a stale copy
			data_out <= ~data_out;
			if (wait_ff != 2'h0) wait_ff = wait_ff - 2'h1;
		end
	end
endmodule : adc_front_model

// ===== result_math.sv
`timescale 1ns/1ns
module result_math
	import shunt_monitor_pkg::*;
#(
	parameter int CURRENT_DIV = CURRENT_DIV_DEFAULT,
	parameter int POWER_DIV   = POWER_DIV_DEFAULT
) (
	input  wire logic signed [15:0] shunt_in,
	input  wire logic [15:0]        bus_in,
	input  wire logic [15:0]        cal_in,
	output logic [15:0]             current_out,
	output logic [15:0]             power_out,
	output logic                    overflow_out
);
	logic signed [31:0] cur_full;
	logic [15:0]        cur_mag;
	logic [31:0]        pow_full;
	logic               cur_ovf;

	assign cur_full     = (32'(shunt_in) * $signed({17'h00000, cal_in[CAL_VALUE_W-1:0]})) / CURRENT_DIV;
	assign cur_ovf      = (cur_full > 32'sh00007FFF) || (cur_full < -32'sh00008000);
	assign current_out  = cur_full[15:0];
	// power uses the magnitude of the current so the result stays unsigned
	assign cur_mag      = current_out[15] ? 16'(-current_out) : current_out;
	assign pow_full     = ({16'h0000, cur_mag} * {16'h0000, bus_in}) / 32'(POWER_DIV);
	assign power_out    = pow_full[15:0];
	assign overflow_out = cur_ovf || (|pow_full[31:16]);

endmodule : result_math

// ===== sample_averager.sv
`timescale 1ns/1ns
module sample_averager
	import shunt_monitor_pkg::*;
#(
	parameter int ACC_W = 27
) (
	input  wire logic               clk_in,
	input  wire logic               rst_in,
	input  wire logic               clear_in,
	input  wire logic               valid_in,
	input  wire logic [3:0]         shift_in,
	input  wire logic signed [15:0] sample_in,
	output logic                    done_out,
	output logic signed [15:0]      avg_out
);
	logic        [10:0]      cnt_ff;
	logic signed [ACC_W-1:0] acc_ff;
	logic signed [ACC_W-1:0] sum;
	logic        [10:0]      target;

	assign sum    = acc_ff + ACC_W'(sample_in);
	assign target = (11'h001 << shift_in) - 11'h001;

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			cnt_ff   <= 11'h000;
			acc_ff   <= '0;
			done_out <= 1'b0;
			avg_out  <= 16'h0000;
		end else begin
			done_out <= 1'b0;
			if (clear_in) begin
				cnt_ff <= 11'h000;
				acc_ff <= '0;
			end else if (valid_in) begin
				if (cnt_ff == target) begin
					// power-of-two counts, so the mean is a plain shift
					avg_out  <= 16'(sum >>> shift_in);
					done_out <= 1'b1;
					cnt_ff   <= 11'h000;
					acc_ff   <= '0;
				end else begin
					cnt_ff <= cnt_ff + 11'h001;
					acc_ff <= sum;
				end
			end
		end
	end

endmodule : sample_averager

// ===== shunt_monitor_pkg.sv
package shunt_monitor_pkg;

	// register offsets
	localparam logic [7:0]  CFG_ADDR        = 8'h00;
	localparam logic [7:0]  SHUNT_ADDR      = 8'h01;
	localparam logic [7:0]  BUS_ADDR        = 8'h02;
	localparam logic [7:0]  POWER_ADDR      = 8'h03;
	localparam logic [7:0]  CURRENT_ADDR    = 8'h04;
	localparam logic [7:0]  CAL_ADDR        = 8'h05;
	localparam logic [7:0]  LIMIT_FN_ADDR   = 8'h06;
	localparam logic [7:0]  LIMIT_VAL_ADDR  = 8'h07;

	// reset values
	localparam logic [15:0] CFG_RESET       = 16'h4127;
	localparam logic [15:0] RESULT_RESET    = 16'h0000;
	localparam logic [15:0] CAL_RESET       = 16'h0000;
	localparam logic [15:0] LIMIT_FN_RESET  = 16'h0000;
	localparam logic [15:0] LIMIT_VAL_RESET = 16'h0000;

	// configuration fields
	localparam int          CFG_SOFT_RST_BIT = 15;
	localparam int          CFG_AVG_LSB      = 9;
	localparam int          OP_SHUNT_BIT     = 0;
	localparam int          OP_BUS_BIT       = 1;
	localparam int          OP_CONT_BIT      = 2;
	localparam int          CAL_VALUE_W      = 15;
	localparam int          BUS_VALUE_W      = 15;

	// limit-function fields
	localparam int          EN_SHUNT_OVER    = 15;
	localparam int          EN_SHUNT_UNDER   = 14;
	localparam int          EN_RAIL_OVER     = 13;
	localparam int          EN_RAIL_UNDER    = 12;
	localparam int          EN_POWER_OVER    = 11;
	localparam int          EN_DONE_PIN      = 10;
	localparam int          FLAG_FUNC_BIT    = 4;
	localparam int          FLAG_DONE_BIT    = 3;
	localparam int          FLAG_OVF_BIT     = 2;
	localparam int          POLARITY_BIT     = 1;
	localparam int          LATCH_BIT        = 0;

	// result scaling
	localparam int          SHUNT_LSB_NV     = 2500;
	localparam int          BUS_LSB_UV       = 1250;
	localparam int          POWER_LSB_RATIO  = 25;
	localparam int          UV_PER_V         = 1000000;
	localparam int          POWER_DIV_DEFAULT   = POWER_LSB_RATIO * UV_PER_V / BUS_LSB_UV;
	localparam int          CURRENT_DIV_DEFAULT = 2048;

	typedef enum logic [1:0] {SEQ_IDLE, SEQ_SHUNT, SEQ_BUS, SEQ_MATH} seq_state_e;

	// averaging code to log2 of sample count: 1,4,16,64,128,256,512,1024
	function automatic logic [3:0] avg_shift(input logic [2:0] code);
		case (code)
			3'h0: avg_shift = 4'h0;
			3'h1: avg_shift = 4'h2;
			3'h2: avg_shift = 4'h4;
			3'h3: avg_shift = 4'h6;
			3'h4: avg_shift = 4'h7;
			3'h5: avg_shift = 4'h8;
			3'h6: avg_shift = 4'h9;
			default: avg_shift = 4'hA;
		endcase
	endfunction : avg_shift

endpackage : shunt_monitor_pkg

// ===== shunt_power_monitor_regs.sv
`timescale 1ns/1ns
// Notes on behaviour
// - mode 000/100 power-down, 001-011 triggered, 101-111 continuous shunt/bus/both
// - after reset the mode field selects continuous shunt and bus
// - shunt result is signed 16-bit, 2.5 uV step, 7FFF is 81.9175 mV
// - shunt and bus results hold the averaged value when averaging is on; current and power are computed from them
// - bus result unsigned in bits 14..0, 1.25 mV step, top bit reads zero
// - power step is fixed at 25 times the current step
// - power result is current result times bus result, read-only
// - current result is shunt result times calibration, signed, read-only
// - host writes a 15-bit calibration value, top bit unused
// - with several limit enables set only the highest-numbered one compares
// - shunt-over enable: warn when shunt result exceeds the limit
// - shunt-under enable: warn when shunt result falls below the limit
// - bus-over enable: warn when bus result exceeds the limit
// - bus-under enable: warn when bus result falls below the limit
// - limit-function register resets to zero, holds enables and flag settings
// - power-over enable: warn when power result exceeds the limit
// - done flag set after math; single-shot clears on read or run write
// - latch holds warning and flag until read; transparent follows each result
// - configuration write aborts a conversion and restarts with new settings
module shunt_power_monitor_regs
	import shunt_monitor_pkg::*;
#(
	parameter int CURRENT_DIV = CURRENT_DIV_DEFAULT,
	parameter int POWER_DIV   = POWER_DIV_DEFAULT
) (
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	input  wire logic [7:0]  reg_addr_in,
	input  wire logic        reg_wr_in,
	input  wire logic [15:0] reg_wdata_in,
	input  wire logic        reg_rd_in,
	output logic [15:0]      reg_rdata_out,
	input  wire logic [15:0] adc_data_in,
	input  wire logic        adc_valid_in,
	output logic             adc_req_out,
	output logic             adc_bus_sel_out,
	output logic             alert_active_out,
	output logic             alert_oe_n_out
);
	logic [15:0]        cfg_ff;
	logic [15:0]        cal_ff;
	logic [15:0]        limit_ff;
	logic [5:0]         enables_ff;
	logic               polarity_ff;
	logic               latch_ff;
	logic signed [15:0] shunt_ff;
	logic [15:0]        bus_ff;
	logic [15:0]        power_ff;
	logic [15:0]        current_ff;
	logic               func_flag_ff;
	logic               done_flag_ff;
	logic               ovf_flag_ff;
	seq_state_e         seq_ff;
	seq_state_e         nxt_seq;

	logic               cfg_wr;
	logic               soft_rst;
	logic               mask_rd;
	logic [2:0]         op_mode;
	logic [2:0]         wr_mode;
	logic               collecting;
	logic               avg_done;
	logic signed [15:0] avg_value;
	logic signed [15:0] adc_sample;
	logic [15:0]        cur_w;
	logic [15:0]        pow_w;
	logic               ovf_w;
	logic               math_now;
	logic               limit_hit;
	logic               asserted;
	logic [15:0]        nxt_rdata;

	assign cfg_wr     = reg_wr_in && (reg_addr_in == CFG_ADDR);
	assign soft_rst   = cfg_wr && reg_wdata_in[CFG_SOFT_RST_BIT];
	assign mask_rd    = reg_rd_in && (reg_addr_in == LIMIT_FN_ADDR);
	assign op_mode    = cfg_ff[2:0];
	assign wr_mode    = reg_wdata_in[2:0];
	assign collecting = (seq_ff == SEQ_SHUNT) || (seq_ff == SEQ_BUS);
	assign math_now   = (seq_ff == SEQ_MATH) && !cfg_wr;
	// bus channel is unsigned; the spare top bit is forced low
	assign adc_sample = (seq_ff == SEQ_BUS) ? {1'b0, adc_data_in[BUS_VALUE_W-1:0]} : adc_data_in;

	// registers reset to defaults on the self-clearing reset bit too
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			cfg_ff <= CFG_RESET;
		end else if (soft_rst) begin
			cfg_ff <= CFG_RESET;
		end else if (cfg_wr) begin
			cfg_ff <= {1'b0, reg_wdata_in[14:0]};
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			cal_ff      <= CAL_RESET;
			limit_ff    <= LIMIT_VAL_RESET;
			enables_ff  <= LIMIT_FN_RESET[15:10];
			polarity_ff <= LIMIT_FN_RESET[POLARITY_BIT];
			latch_ff    <= LIMIT_FN_RESET[LATCH_BIT];
		end else if (soft_rst) begin
			cal_ff      <= CAL_RESET;
			limit_ff    <= LIMIT_VAL_RESET;
			enables_ff  <= LIMIT_FN_RESET[15:10];
			polarity_ff <= LIMIT_FN_RESET[POLARITY_BIT];
			latch_ff    <= LIMIT_FN_RESET[LATCH_BIT];
		end else if (reg_wr_in) begin
			if (reg_addr_in == CAL_ADDR) begin
				cal_ff <= {1'b0, reg_wdata_in[CAL_VALUE_W-1:0]};
			end
			if (reg_addr_in == LIMIT_VAL_ADDR) begin
				limit_ff <= reg_wdata_in;
			end
			if (reg_addr_in == LIMIT_FN_ADDR) begin
				enables_ff  <= reg_wdata_in[15:10];
				polarity_ff <= reg_wdata_in[POLARITY_BIT];
				latch_ff    <= reg_wdata_in[LATCH_BIT];
			end
		end
	end

	// conversion sequencer
	always_comb begin
		nxt_seq = seq_ff;
		if (soft_rst) begin
			nxt_seq = SEQ_SHUNT;
		end else if (cfg_wr) begin
			// abort and restart with the freshly written mode
			if (wr_mode[OP_SHUNT_BIT]) begin
				nxt_seq = SEQ_SHUNT;
			end else if (wr_mode[OP_BUS_BIT]) begin
				nxt_seq = SEQ_BUS;
			end else begin
				nxt_seq = SEQ_IDLE;
			end
		end else begin
			case (seq_ff)
				SEQ_IDLE: nxt_seq = SEQ_IDLE;
				SEQ_SHUNT: begin
					if (avg_done) begin
						nxt_seq = op_mode[OP_BUS_BIT] ? SEQ_BUS : SEQ_MATH;
					end
				end
				SEQ_BUS: begin
					if (avg_done) begin
						nxt_seq = SEQ_MATH;
					end
				end
				SEQ_MATH: begin
					if (!op_mode[OP_CONT_BIT]) begin
						nxt_seq = SEQ_IDLE;
					end else if (op_mode[OP_SHUNT_BIT]) begin
						nxt_seq = SEQ_SHUNT;
					end else begin
						nxt_seq = SEQ_BUS;
					end
				end
				default: nxt_seq = SEQ_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			seq_ff <= SEQ_SHUNT;
		end else begin
			seq_ff <= nxt_seq;
		end
	end

	// request stays up across every sample of an averaged set
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			adc_req_out     <= 1'b0;
			adc_bus_sel_out <= 1'b0;
		end else begin
			adc_req_out     <= (nxt_seq == SEQ_SHUNT) || (nxt_seq == SEQ_BUS);
			adc_bus_sel_out <= (nxt_seq == SEQ_BUS);
		end
	end

	// a sample landing in the hand-over cycle belongs to neither set
	sample_averager u_avg (
		.clk_in    (clk_in),
		.rst_in    (rst_in),
		.clear_in  (cfg_wr || avg_done || !collecting || !adc_req_out),
		.valid_in  (adc_valid_in),
		.shift_in  (avg_shift(cfg_ff[CFG_AVG_LSB+2:CFG_AVG_LSB])),
		.sample_in (adc_sample),
		.done_out  (avg_done),
		.avg_out   (avg_value)
	);

	result_math #(
		.CURRENT_DIV (CURRENT_DIV),
		.POWER_DIV   (POWER_DIV)
	) u_math (
		.shunt_in     (shunt_ff),
		.bus_in       (bus_ff),
		.cal_in       (cal_ff),
		.current_out  (cur_w),
		.power_out    (pow_w),
		.overflow_out (ovf_w)
	);

	// results; a half-finished set is discarded on abort
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			shunt_ff   <= RESULT_RESET;
			bus_ff     <= RESULT_RESET;
			power_ff   <= RESULT_RESET;
			current_ff <= RESULT_RESET;
		end else if (soft_rst) begin
			shunt_ff   <= RESULT_RESET;
			bus_ff     <= RESULT_RESET;
			power_ff   <= RESULT_RESET;
			current_ff <= RESULT_RESET;
		end else begin
			if (avg_done && (seq_ff == SEQ_SHUNT) && !cfg_wr) begin
				shunt_ff <= avg_value;
			end
			if (avg_done && (seq_ff == SEQ_BUS) && !cfg_wr) begin
				bus_ff <= {1'b0, avg_value[BUS_VALUE_W-1:0]};
			end
			if (math_now) begin
				current_ff <= cur_w;
				power_ff   <= pow_w;
			end
		end
	end

	// only the highest enabled comparison counts
	always_comb begin
		limit_hit = 1'b0;
		if (enables_ff[EN_SHUNT_OVER-10]) begin
			limit_hit = shunt_ff > $signed(limit_ff);
		end else if (enables_ff[EN_SHUNT_UNDER-10]) begin
			limit_hit = shunt_ff < $signed(limit_ff);
		end else if (enables_ff[EN_RAIL_OVER-10]) begin
			limit_hit = bus_ff > limit_ff;
		end else if (enables_ff[EN_RAIL_UNDER-10]) begin
			limit_hit = bus_ff < limit_ff;
		end else if (enables_ff[EN_POWER_OVER-10]) begin
			limit_hit = pow_w > limit_ff;
		end
	end

	// a hit in the cycle of the clearing read wins over the clear
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			func_flag_ff <= 1'b0;
		end else if (soft_rst) begin
			func_flag_ff <= 1'b0;
		end else if (math_now && limit_hit) begin
			func_flag_ff <= 1'b1;
		end else if (math_now && !latch_ff) begin
			func_flag_ff <= 1'b0;
		end else if (mask_rd && latch_ff) begin
			func_flag_ff <= 1'b0;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			done_flag_ff <= 1'b0;
			ovf_flag_ff  <= 1'b0;
		end else if (soft_rst) begin
			done_flag_ff <= 1'b0;
			ovf_flag_ff  <= 1'b0;
		end else begin
			if (math_now) begin
				done_flag_ff <= 1'b1;
				ovf_flag_ff  <= ovf_w;
			end else if (!op_mode[OP_CONT_BIT] && (mask_rd || (cfg_wr && (wr_mode[1:0] != 2'h0)))) begin
				done_flag_ff <= 1'b0;
			end
		end
	end

	// open-drain pin: normal polarity pulls low while asserted
	assign asserted = func_flag_ff || (enables_ff[EN_DONE_PIN-10] && done_flag_ff);

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			alert_active_out <= 1'b0;
			alert_oe_n_out   <= 1'b1;
		end else begin
			alert_active_out <= asserted;
			alert_oe_n_out   <= polarity_ff ? asserted : !asserted;
		end
	end

	// register reads
	always_comb begin
		case (reg_addr_in)
			CFG_ADDR:       nxt_rdata = cfg_ff;
			SHUNT_ADDR:     nxt_rdata = shunt_ff;
			BUS_ADDR:       nxt_rdata = bus_ff;
			POWER_ADDR:     nxt_rdata = power_ff;
			CURRENT_ADDR:   nxt_rdata = current_ff;
			CAL_ADDR:       nxt_rdata = cal_ff;
			LIMIT_FN_ADDR:  nxt_rdata = {enables_ff, 5'h00, func_flag_ff, done_flag_ff, ovf_flag_ff,
			                             polarity_ff, latch_ff};
			LIMIT_VAL_ADDR: nxt_rdata = limit_ff;
			default:        nxt_rdata = 16'h0000;
		endcase
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			reg_rdata_out <= 16'h0000;
		end else if (reg_rd_in) begin
			reg_rdata_out <= nxt_rdata;
		end
	end

	// checks
	a_mode_decode: assert property (@(posedge clk_in) disable iff (rst_in)
		(cfg_wr && !soft_rst && reg_wdata_in[1:0] == 2'h0) |=> seq_ff == SEQ_IDLE)
		else $error("power-down write did not idle the sequencer");

	a_reset_mode: assert property (@(posedge clk_in) disable iff (rst_in)
		$fell(rst_in) |-> (op_mode == 3'h7 && seq_ff == SEQ_SHUNT))
		else $error("mode after reset is not continuous shunt and bus");

	a_bus_top_zero: assert property (@(posedge clk_in) disable iff (rst_in)
		!bus_ff[15] && !cal_ff[15])
		else $error("bus result or calibration top bit set");

	a_zero_cal: assert property (@(posedge clk_in) disable iff (rst_in)
		(math_now && cal_ff == 16'h0000) |=> (current_ff == 16'h0000 && power_ff == 16'h0000))
		else $error("zero calibration gave nonzero current or power");

	a_done_after: assert property (@(posedge clk_in) disable iff (rst_in)
		math_now |=> done_flag_ff ##1 alert_active_out || !enables_ff[EN_DONE_PIN-10])
		else $error("done flag or done alert missing after math");

	a_latch_hold: assert property (@(posedge clk_in) disable iff (rst_in)
		(func_flag_ff && latch_ff && !mask_rd && !soft_rst) |=> func_flag_ff)
		else $error("latched warning dropped without a read");

	a_abort_restart: assert property (@(posedge clk_in) disable iff (rst_in)
		(cfg_wr && !soft_rst && reg_wdata_in[0]) |=> (seq_ff == SEQ_SHUNT && adc_req_out && !adc_bus_sel_out))
		else $error("configuration write did not restart on shunt");

	// a host write right after the math cycle legally restarts the sequencer
	a_trigger_stop: assert property (@(posedge clk_in) disable iff (rst_in)
		(math_now && !op_mode[2]) |=> seq_ff == SEQ_IDLE ##1 (seq_ff == SEQ_IDLE || $past(cfg_wr)))
		else $error("triggered mode did not stop after one sequence");

	a_shunt_over: assert property (@(posedge clk_in) disable iff (rst_in)
		(math_now && enables_ff[5] && shunt_ff > $signed(limit_ff)) |=> func_flag_ff ##1 alert_active_out)
		else $error("shunt over limit did not raise the warning");

	a_priority: assert property (@(posedge clk_in) disable iff (rst_in)
		(math_now && enables_ff[5] && shunt_ff <= $signed(limit_ff) && !latch_ff) |=> !func_flag_ff)
		else $error("lower-priority comparison raised the warning");

	c_continuous_loop: cover property (@(posedge clk_in) disable iff (rst_in)
		seq_ff == SEQ_MATH ##1 seq_ff == SEQ_SHUNT);
	c_alert_raised: cover property (@(posedge clk_in) disable iff (rst_in)
		$rose(func_flag_ff));
	c_triggered_done: cover property (@(posedge clk_in) disable iff (rst_in)
		!op_mode[2] && $rose(done_flag_ff));

endmodule : shunt_power_monitor_regs

// ===== shunt_power_monitor_regs_tb_top.sv
`timescale 1ns/1ns
module shunt_power_monitor_regs_tb_top
	import shunt_monitor_pkg::*;
;
	logic        clk, rst, wr, rd, valid, req, sel, alert, oe_n;
	logic [7:0]  addr;
	logic [15:0] wdata, rdata, adc_data, sh_val, bus_val, got, es, eb;
	logic [10:0] n_samp;
	logic [1:0]  gap;
	int          fails, tests_run;
	logic [15:0] en_t [10] = '{16'h8000, 16'h8000, 16'h4000, 16'h2000, 16'h1000,
		16'h1000, 16'h0800, 16'h0800, 16'hA000, 16'h8002};
	logic [15:0] lim_t [10] = '{16'h0700, 16'h0900, 16'h0900, 16'h4000, 16'h4000,
		16'h5000, 16'h03E7, 16'h03E8, 16'h0900, 16'h0700};
	logic [9:0]  hit_t = 10'b1001101101;

	shunt_power_monitor_regs u_shunt_power_monitor_regs (
		.clk_in(clk), .rst_in(rst), .reg_addr_in(addr), .reg_wr_in(wr), .reg_wdata_in(wdata),
		.reg_rd_in(rd), .reg_rdata_out(rdata), .adc_data_in(adc_data), .adc_valid_in(valid),
		.adc_req_out(req), .adc_bus_sel_out(sel), .alert_active_out(alert), .alert_oe_n_out(oe_n));
	adc_front_model u_adc_front_model (
		.clk_in(clk), .req_in(req), .sel_in(sel), .shunt_in(sh_val), .bus_in(bus_val),
		.count_in(n_samp), .gap_in(gap), .data_out(adc_data), .valid_out(valid));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task report_and_stop;
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : report_and_stop

	task chk(input logic [15:0] g, input logic [15:0] e);
		tests_run++;
		if (g !== e) begin
			fails++;
			$display("unexpected value at %0t: got %h exp %h", $time, g, e);
		end
	endtask : chk

	task wr_reg(input logic [7:0] a, input logic [15:0] d);
		@(negedge clk);
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(negedge clk);
		wr = 1'b0;
	endtask : wr_reg

	task rd_reg(input logic [7:0] a);
		@(negedge clk);
		addr = a;
		rd = 1'b1;
		@(negedge clk);
		rd = 1'b0;
		got = rdata;
	endtask : rd_reg

	// waits for math cycles, seen as falls of the request
	task settle(input int falls);
		int   f;
		logic p;
		f = 0;
		p = req;
		for (int c = 0; c < 400 && f < falls; c++) begin
			@(negedge clk);
			if (p === 1'b1 && req === 1'b0) f++;
			p = req;
		end
		if (f < falls) begin
			fails++;
			$display("unexpected hang at %0t: got %h exp %h", $time, f, falls);
			report_and_stop();
		end
		repeat (3) @(negedge clk);
	endtask : settle

	function automatic logic [15:0] exp_cur(int s, int c);
		return 16'(s * c / CURRENT_DIV_DEFAULT);
	endfunction : exp_cur

	function automatic logic [15:0] exp_pow(int cur, int b);
		return 16'((cur < 0 ? -cur : cur) * b / POWER_DIV_DEFAULT);
	endfunction : exp_pow

	// n samples per set; base picked so the mean is exact
	task meas(input int k, input int cal, input int b, input int n);
		sh_val = 16'(2048 * k - (n > 1));
		bus_val = 16'(b - (n > 1));
		n_samp = 11'(n);
		gap = 2'($urandom_range(0, 3));
		wr_reg(CAL_ADDR, 16'(cal));
		settle(2);
		es = 16'(2048 * k);
		eb = 16'(b & 32'h7FFF);
		rd_reg(SHUNT_ADDR);
		chk(got, es);
		rd_reg(BUS_ADDR);
		chk(got, eb);
		rd_reg(CURRENT_ADDR);
		chk(got, exp_cur(2048 * k, cal));
		rd_reg(POWER_ADDR);
		chk(got, exp_pow(k * cal, b & 32'h7FFF));
	endtask : meas

	initial begin
		void'($urandom(32'h52CD));
		{rst, wr, rd, addr, wdata, sh_val, bus_val, gap} = '0;
		rst = 1'b1;
		n_samp = 11'h001;
		fails = 0;
		tests_run = 0;
		repeat (12) @(negedge clk);
		rst = 1'b0;
		rd_reg(LIMIT_FN_ADDR);
		chk(got, 16'h0000);
		rd_reg(CFG_ADDR);
		chk({13'h0000, got[2:0]}, 16'h0007);
		for (int a = 1; a < 6; a++) begin
			rd_reg(8'(a));
			chk(got, 16'h0000);
		end
		rd_reg(8'h08);
		chk(got, 16'h0000);
		wr_reg(CAL_ADDR, 16'hFFFF);
		rd_reg(CAL_ADDR);
		chk(got, 16'h7FFF);
		$display("test reset and calibration done");
		meas(1, 1000, 20000, 1);
		wr_reg(CURRENT_ADDR, 16'h1234);
		rd_reg(CURRENT_ADDR);
		chk(got, 16'h03E8);
		meas(-1, 1000, 32'h8000 + 20000, 1);
		wr_reg(CFG_ADDR, 16'h4327);
		meas(-3, 2000, 20000, 4);
		wr_reg(CFG_ADDR, CFG_RESET);
		for (int i = 0; i < 8; i++) begin
			meas(int'($urandom_range(0, 30)) - 15, 4 * $urandom_range(1, 500),
				5000 * $urandom_range(1, 6) + ($urandom_range(0, 1) << 15), 1);
		end
		$display("test results done");
		for (int m = 0; m < 8; m++) begin
			sh_val = 16'(2048 * (m + 2));
			bus_val = 16'(1000 * (m + 1));
			wr_reg(CFG_ADDR, 16'h4120 | 16'(m));
			if (m[1:0] == 2'h0) repeat (20) @(negedge clk);
			else settle(1);
			if (m[0]) es = sh_val;
			if (m[1]) eb = bus_val;
			rd_reg(SHUNT_ADDR);
			chk(got, es);
			rd_reg(BUS_ADDR);
			chk(got, eb);
			if (!m[2]) begin
				repeat (10) @(negedge clk);
				chk({15'h0000, req}, 16'h0000);
				if (m[1:0] != 2'h0) begin
					rd_reg(LIMIT_FN_ADDR);
					chk({15'h0000, got[3]}, 16'h0001);
					rd_reg(LIMIT_FN_ADDR);
					chk({15'h0000, got[3]}, 16'h0000);
				end
			end
		end
		wr_reg(CFG_ADDR, CFG_RESET);
		$display("test modes done");
		meas(1, 1000, 20000, 1);
		for (int i = 0; i < 10; i++) begin
			wr_reg(LIMIT_VAL_ADDR, lim_t[i]);
			wr_reg(LIMIT_FN_ADDR, en_t[i]);
			settle(2);
			chk({15'h0000, alert}, {15'h0000, hit_t[i]});
			chk({15'h0000, oe_n}, {15'h0000, en_t[i][1] ~^ hit_t[i]});
			rd_reg(LIMIT_FN_ADDR);
			chk({15'h0000, got[4]}, {15'h0000, hit_t[i]});
		end
		wr_reg(LIMIT_VAL_ADDR, 16'h0700);
		wr_reg(LIMIT_FN_ADDR, 16'h8001);
		settle(2);
		chk({15'h0000, alert}, 16'h0001);
		wr_reg(LIMIT_VAL_ADDR, 16'h0900);
		settle(2);
		chk({15'h0000, alert}, 16'h0001);
		rd_reg(LIMIT_FN_ADDR);
		chk({15'h0000, got[4]}, 16'h0001);
		settle(2);
		chk({15'h0000, alert}, 16'h0000);
		$display("test limits done");
		wr_reg(CFG_ADDR, 16'h8000);
		rd_reg(LIMIT_FN_ADDR);
		chk(got, 16'h0000);
		rd_reg(CAL_ADDR);
		chk(got, 16'h0000);
		rd_reg(CFG_ADDR);
		chk({13'h0000, got[2:0]}, 16'h0007);
		$display("test soft reset done");
		sh_val = 16'(2048 * 15);
		wr_reg(LIMIT_FN_ADDR, 16'h0400);
		wr_reg(CAL_ADDR, 16'h7FFF);
		settle(2);
		chk({15'h0000, alert}, 16'h0001);
		rd_reg(LIMIT_FN_ADDR);
		chk({13'h0000, got[3:1]}, 16'h0006);
		$display("test done pin and overflow done");
		report_and_stop();
	end
endmodule : shunt_power_monitor_regs_tb_top
